/* File: core/carc_top.sv */
// clock source selection, start-up timing and reset sequencing
// assumes analog detectors and pins arrive asynchronously, register port and
// suspend/wake/interrupt-enable signals come from logic on SYS_CLK
module carc_top
   import carc_pkg::*;
#(
   parameter int unsigned P_STARTUP_CYC      = STARTUP_CYC,
   parameter int unsigned P_WATCH_CYC        = WATCH_CYC,
   parameter int unsigned P_STABLE_CYC       = STABLE_CYC,
   parameter int unsigned P_RESUME_SHORT_CYC = RESUME_SHORT_CYC,
   parameter int unsigned P_RESUME_LONG_CYC  = RESUME_LONG_CYC,
   parameter int unsigned P_WDOG_HOLD_CYC    = WDOG_HOLD_CYC,
   parameter int unsigned P_WAKE_BASE_CYC    = WAKE_BASE_CYC
)
(
   input  wire logic       SYS_CLK,
   input  wire logic       RST,
   input  wire logic       CE,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       LV_BELOW,
   input  wire logic       BROWNOUT_TRIP,
   input  wire logic       EXT_OSC_OK,
   input  wire logic       XTAL_IN,
   input  wire logic       USB_TRAFFIC,
   input  wire logic       SUSPEND_REQ,
   input  wire logic       WAKE_EVENT,
   input  wire logic       WAKE_INT_EN,
   input  wire logic [1:0] CAUSE_CLR,
   output logic            SYS_RESET,
   output logic            PARTIAL_SUSPEND,
   output logic            CPU_RUN,
   output logic            RESTART_AT_ZERO,
   output logic            CORE_CLK_EN,
   output logic            INT_OSC_EN,
   output logic            EXT_OSC_EN,
   output logic            CLK_SEL_EXT,
   output logic            CLK_TUNE_EN,
   output logic            XTAL_OUT_CLK_SEL,
   output logic            XTAL_OUT_O,
   output logic            XTAL_OUT_OE_N,
   output logic            XTAL_IN_PULLDOWN,
   output logic            AUX_PORT_BIT1,
   output logic            WAKE_IRQ,
   output logic            CAUSE_LV_BROWNOUT,
   output logic            CAUSE_WATCHDOG
);

   function automatic logic [CNT_W-1:0] fn_last(input int unsigned cyc);
      fn_last = (cyc > 1) ? CNT_W'(cyc - 1) : '0;
   endfunction

   function automatic logic [CNT_W-1:0] fn_wake_last(input logic [2:0] adj);
      logic [CNT_W-1:0] per;
      per = CNT_W'(P_WAKE_BASE_CYC) << adj;
      fn_wake_last = per - CNT_W'(1);
   endfunction

   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic              lv_s;
   logic              bo_s;
   logic              osc_ok_s;
   logic              xin_s;
   carc_cfg_t         cfg_reg;
   logic              ext_mode_reg;
   logic              ext_mode_next;
   logic              usb_seen_reg;
   carc_state_t       state_reg;
   carc_state_t       state_next;
   logic [CNT_W-1:0]  cnt_reg;
   logic [CNT_W-1:0]  cnt_lim;
   logic              cnt_hit;
   logic [CNT_W-1:0]  wd_cnt_reg;
   logic              wd_hit;
   logic [CNT_W-1:0]  wk_cnt_reg;
   logic              wk_hit;
   logic              wr_cfg;
   logic              wr_wdclr;
   logic              lv_trip;
   logic              ext_go;
   logic              to_reset;

   assign lv_s     = sync2_reg[0];
   assign bo_s     = sync2_reg[1];
   assign osc_ok_s = sync2_reg[2];
   assign xin_s    = sync2_reg[3];
   assign wr_cfg   = WR && (ADDR == ADDR_CLK_CFG);
   assign wr_wdclr = WR && (ADDR == ADDR_WDOG_CLR);
   assign lv_trip  = lv_s && !cfg_reg.lvr_dis;
   assign ext_go   = wr_cfg && WDATA[BIT_EXT_EN] && !ext_mode_reg;
   assign cnt_hit  = (cnt_reg >= cnt_lim);
   assign wd_hit   = (wd_cnt_reg >= fn_last(P_WATCH_CYC));
   assign wk_hit   = (wk_cnt_reg >= fn_wake_last(cfg_reg.wake_adj));
   assign to_reset = (state_next == ST_LV_HOLD) || (state_next == ST_WDOG);

   // detector and pin levels are asynchronous; stage two only is read
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else if (CE)
      begin
         sync1_reg <= {XTAL_IN, EXT_OSC_OK, BROWNOUT_TRIP, LV_BELOW};
         sync2_reg <= sync1_reg;
      end
   end

   always_comb
   begin
      unique case (state_reg)
         ST_STARTUP: cnt_lim = fn_last(P_STARTUP_CYC);
         ST_EXT_ST:  cnt_lim = fn_last(P_STABLE_CYC);
         ST_RESUME:  cnt_lim = cfg_reg.resume_long ? fn_last(P_RESUME_LONG_CYC)
                                                   : fn_last(P_RESUME_SHORT_CYC);
         ST_WAKE_IN: cnt_lim = fn_last(WAKE_INT_CYC);
         ST_WDOG:    cnt_lim = fn_last(P_WDOG_HOLD_CYC);
         default:    cnt_lim = '0;
      endcase
   end

   always_comb
   begin
      state_next = state_reg;
      if (bo_s)
         state_next = ST_LV_HOLD;
      else
      begin
         unique case (state_reg)
            ST_LV_HOLD:
               if (!lv_s)
                  state_next = ST_STARTUP;
            ST_STARTUP:
               if (lv_s)
                  state_next = ST_LV_HOLD;
               else if (cnt_hit)
                  state_next = ST_RUN;
            ST_RUN:
               if (lv_trip)
                  state_next = ST_LV_HOLD;
               else if (wd_hit)
                  state_next = ST_WDOG;
               else if (SUSPEND_REQ)
                  state_next = ST_SUSPEND;
               else if (ext_go)
                  state_next = ST_EXT_ST;
            ST_EXT_ST:
               if (lv_trip)
                  state_next = ST_LV_HOLD;
               else if (cnt_hit)
                  state_next = ST_RESUME;
            ST_RESUME:
               if (lv_trip)
                  state_next = ST_LV_HOLD;
               else if (cnt_hit)
                  state_next = ST_RUN;
            ST_SUSPEND:
               // monitor ignored here; only brown-out acts in suspend
               if (WAKE_EVENT)
                  state_next = cfg_reg.ext_en ? ST_EXT_ST : ST_WAKE_IN;
            ST_WAKE_IN:
               if (lv_trip)
                  state_next = ST_LV_HOLD;
               else if (cnt_hit)
                  state_next = ST_RUN;
            ST_WDOG:
               if (lv_trip)
                  state_next = ST_LV_HOLD;
               else if (cnt_hit)
                  state_next = ST_RUN;
            default:
               state_next = ST_LV_HOLD;
         endcase
      end
   end

   always_comb
   begin
      ext_mode_next = ext_mode_reg;
      if (state_next == ST_LV_HOLD)
         ext_mode_next = 1'b0;
      else if ((state_reg == ST_SUSPEND) && (state_next == ST_WAKE_IN))
         ext_mode_next = 1'b0;
      else if ((state_reg != ST_EXT_ST) && (state_next == ST_EXT_ST))
         ext_mode_next = 1'b1;
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         state_reg    <= ST_LV_HOLD;
         ext_mode_reg <= 1'b0;
      end
      else if (CE)
      begin
         state_reg    <= state_next;
         ext_mode_reg <= ext_mode_next;
      end
   end

   // one shared timer; it restarts on every state change
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         cnt_reg <= '0;
      else if (CE)
      begin
         if (state_next != state_reg)
            cnt_reg <= '0;
         else if ((state_reg == ST_EXT_ST) && !osc_ok_s)
            cnt_reg <= '0;
         else if (!cnt_hit)
            cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // watchdog is held at zero outside normal running, in every state but ST_RUN
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         wd_cnt_reg <= '0;
      else if (CE)
      begin
         if (wr_wdclr || (state_reg != ST_RUN))
            wd_cnt_reg <= '0;
         else if (!wd_hit)
            wd_cnt_reg <= wd_cnt_reg + CNT_W'(1);
      end
   end

   // a writer of bit 0 in external mode changes nothing until wake
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         cfg_reg <= carc_cfg_t'(CLK_CFG_RESET);
      else if (CE)
      begin
         if (to_reset)
            cfg_reg <= carc_cfg_t'(CLK_CFG_RESET);
         else if (wr_cfg)
            cfg_reg <= carc_cfg_t'(WDATA);
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         usb_seen_reg <= 1'b0;
      else if (CE)
      begin
         if (to_reset || ext_mode_reg || !cfg_reg.tune_en)
            usb_seen_reg <= 1'b0;
         else if (USB_TRAFFIC)
            usb_seen_reg <= 1'b1;
      end
   end

   // disabling the interrupt resets the timer so a new enable gets a full period
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         wk_cnt_reg <= '0;
         WAKE_IRQ   <= 1'b0;
      end
      else if (CE)
      begin
         WAKE_IRQ <= WAKE_INT_EN && wk_hit;
         if (!WAKE_INT_EN || wk_hit)
            wk_cnt_reg <= '0;
         else
            wk_cnt_reg <= wk_cnt_reg + CNT_W'(1);
      end
   end

   // cause bits survive every reset but RST; a new cause beats a clear
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         CAUSE_LV_BROWNOUT <= 1'b0;
         CAUSE_WATCHDOG    <= 1'b0;
      end
      else if (CE)
      begin
         if ((state_next == ST_LV_HOLD) && (state_reg != ST_LV_HOLD))
            CAUSE_LV_BROWNOUT <= 1'b1;
         else if (CAUSE_CLR[0])
            CAUSE_LV_BROWNOUT <= 1'b0;
         if ((state_next == ST_WDOG) && (state_reg != ST_WDOG))
            CAUSE_WATCHDOG <= 1'b1;
         else if (CAUSE_CLR[1])
            CAUSE_WATCHDOG <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         SYS_RESET       <= 1'b1;
         PARTIAL_SUSPEND <= 1'b0;
         CPU_RUN         <= 1'b0;
         RESTART_AT_ZERO <= 1'b0;
      end
      else if (CE)
      begin
         SYS_RESET       <= to_reset || (state_next == ST_STARTUP);
         PARTIAL_SUSPEND <= (state_next == ST_STARTUP);
         CPU_RUN         <= (state_next == ST_RUN);
         RESTART_AT_ZERO <= (state_next == ST_RUN) &&
                            ((state_reg == ST_STARTUP) || (state_reg == ST_WDOG));
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         CORE_CLK_EN <= 1'b1;
         INT_OSC_EN  <= 1'b1;
         EXT_OSC_EN  <= 1'b0;
         CLK_SEL_EXT <= 1'b0;
         CLK_TUNE_EN <= 1'b0;
      end
      else if (CE)
      begin
         CORE_CLK_EN <= (state_next != ST_EXT_ST) && (state_next != ST_SUSPEND);
         INT_OSC_EN  <= !ext_mode_next && (state_next != ST_SUSPEND);
         EXT_OSC_EN  <= ext_mode_next && (state_next != ST_SUSPEND);
         CLK_SEL_EXT <= ext_mode_next;
         CLK_TUNE_EN <= !ext_mode_reg && cfg_reg.tune_en && usb_seen_reg;
      end
   end

   // in external mode the oscillator owns both crystal pins
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         XTAL_OUT_CLK_SEL <= 1'b1;
         XTAL_OUT_O       <= 1'b1;
         XTAL_OUT_OE_N    <= 1'b0;
         XTAL_IN_PULLDOWN <= 1'b1;
         AUX_PORT_BIT1    <= 1'b0;
      end
      else if (CE)
      begin
         XTAL_OUT_CLK_SEL <= !ext_mode_next && !cfg_reg.clkout_dis;
         XTAL_OUT_O       <= 1'b1;
         XTAL_OUT_OE_N    <= ext_mode_next;
         XTAL_IN_PULLDOWN <= !ext_mode_next;
         AUX_PORT_BIT1    <= !ext_mode_next && xin_s;
      end
   end

   // read data valid in the cycle after the strobe only
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         RDATA <= 8'h00;
      else if (CE)
      begin
         if (RD && (ADDR == ADDR_CLK_CFG))
            RDATA <= cfg_reg;
         else
            RDATA <= 8'h00;
      end
   end

endmodule

/* File: core/carc_pkg.sv */
// constants, state codes and field layout for the clock and reset control block
// assumes one 100 MHz clock and an 8-bit register port
package carc_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam logic [7:0] ADDR_CLK_CFG = 8'hF8;
   localparam logic [7:0] ADDR_WDOG_CLR = 8'h26;
   localparam logic [7:0] CLK_CFG_RESET = 8'h00;
   localparam int unsigned BIT_RESUME_LONG = 7;
   localparam int unsigned BIT_WAKE_ADJ_LO = 4;
   localparam int unsigned BIT_LVR_DIS = 3;
   localparam int unsigned BIT_TUNE_EN = 2;
   localparam int unsigned BIT_CLKOUT_DIS = 1;
   localparam int unsigned BIT_EXT_EN = 0;
   localparam int unsigned T_RESUME_SHORT_US = 128;
   localparam int unsigned T_RESUME_LONG_MS = 4;
   localparam int unsigned T_WAKE_INT_US = 8;
   localparam int unsigned T_WDOG_HOLD_MS = 3;
   localparam int unsigned RESUME_SHORT_CYC = T_RESUME_SHORT_US * CLK_MHZ;
   localparam int unsigned RESUME_LONG_CYC = T_RESUME_LONG_MS * 1000 * CLK_MHZ;
   localparam int unsigned WAKE_INT_CYC = T_WAKE_INT_US * CLK_MHZ;
   localparam int unsigned WDOG_HOLD_CYC = T_WDOG_HOLD_MS * 1000 * CLK_MHZ;
   localparam int unsigned STARTUP_CYC = 100000;
   localparam int unsigned WATCH_CYC = 1000000;
   localparam int unsigned STABLE_CYC = 1000;
   localparam int unsigned WAKE_BASE_CYC = 1000;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned SYNC_W = 4;

   typedef struct packed {
      logic       resume_long;
      logic [2:0] wake_adj;
      logic       lvr_dis;
      logic       tune_en;
      logic       clkout_dis;
      logic       ext_en;
   } carc_cfg_t;

   typedef enum logic [7:0] {
      ST_LV_HOLD = 8'h01,
      ST_STARTUP = 8'h02,
      ST_RUN     = 8'h04,
      ST_EXT_ST  = 8'h08,
      ST_RESUME  = 8'h10,
      ST_SUSPEND = 8'h20,
      ST_WAKE_IN = 8'h40,
      ST_WDOG    = 8'h80
   } carc_state_t;
endpackage

/* File: bench/carc_chk.sv */
// checker for carc_top: timing of reset exits, register port and pin modes
// assumes one clock domain and the bench's write-then-read spacing
module carc_chk
#(
   parameter int unsigned P_STARTUP_CYC   = 20,
   parameter int unsigned P_WDOG_HOLD_CYC = 15
)
(
   input wire logic       SYS_CLK,
   input wire logic       RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic       SYS_RESET,
   input wire logic       PARTIAL_SUSPEND,
   input wire logic       CPU_RUN,
   input wire logic       RESTART_AT_ZERO,
   input wire logic       CORE_CLK_EN,
   input wire logic       INT_OSC_EN,
   input wire logic       CLK_SEL_EXT,
   input wire logic       XTAL_OUT_O,
   input wire logic       XTAL_OUT_OE_N,
   input wire logic       XTAL_IN_PULLDOWN,
   input wire logic       AUX_PORT_BIT1,
   input wire logic       CAUSE_WATCHDOG
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int S1 = P_STARTUP_CYC - 1;
   localparam int H1 = P_WDOG_HOLD_CYC - 1;
   default clocking @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   sequence s_release;
      CPU_RUN && RESTART_AT_ZERO;
   endsequence
   sequence s_startup;
      (PARTIAL_SUSPEND && SYS_RESET) ##S1 PARTIAL_SUSPEND;
   endsequence
   property p_cfg_rw;
      logic [7:0] d;
      (WR && ADDR == 8'hF8 && !SYS_RESET, d = WDATA) ##[1:2] (RD && ADDR == 8'hF8)
         |=> RDATA == d;
   endproperty

   a_startup_len: assert property ($rose(PARTIAL_SUSPEND) |-> s_startup ##1 s_release)
      else $error("start-up hold length wrong");
   a_wdog_hold: assert property ($rose(CAUSE_WATCHDOG) |->
      (SYS_RESET && !PARTIAL_SUSPEND) ##H1 SYS_RESET ##1 s_release)
      else $error("watchdog hold length wrong");
   a_restart_cause: assert property (RESTART_AT_ZERO |-> $past(SYS_RESET) && CPU_RUN)
      else $error("restart pulse without reset exit");
   a_restart_once: assert property (RESTART_AT_ZERO |=> !RESTART_AT_ZERO)
      else $error("restart pulse longer than one cycle");
   a_run_no_reset: assert property (CPU_RUN |-> !SYS_RESET && CORE_CLK_EN)
      else $error("processor runs while held");
   a_rd_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data outside read cycle");
   a_clear_wo: assert property ($past(RD) && $past(ADDR) == 8'h26 |-> RDATA == 8'h00)
      else $error("watchdog clear register readable");
   a_cfg_rw: assert property (p_cfg_rw)
      else $error("configuration read-back differs");
   a_int_pins: assert property (!CLK_SEL_EXT |->
      XTAL_IN_PULLDOWN && !XTAL_OUT_OE_N && XTAL_OUT_O)
      else $error("internal mode pin setup wrong");
   a_ext_pins: assert property (CLK_SEL_EXT |->
      XTAL_OUT_OE_N && !XTAL_IN_PULLDOWN && !AUX_PORT_BIT1 && !INT_OSC_EN)
      else $error("external mode pin setup wrong");
   a_ext_halt: assert property ((CPU_RUN && !CLK_SEL_EXT && WR && ADDR == 8'hF8 && WDATA[0])
      |-> ##[1:2] (CLK_SEL_EXT && !CORE_CLK_EN && !CPU_RUN))
      else $error("external enable did not halt clocks");
endmodule

bind carc_top carc_chk #(.P_STARTUP_CYC(P_STARTUP_CYC), .P_WDOG_HOLD_CYC(P_WDOG_HOLD_CYC)) u_chk (
   .SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .SYS_RESET(SYS_RESET), .PARTIAL_SUSPEND(PARTIAL_SUSPEND),
   .CPU_RUN(CPU_RUN), .RESTART_AT_ZERO(RESTART_AT_ZERO), .CORE_CLK_EN(CORE_CLK_EN),
   .INT_OSC_EN(INT_OSC_EN), .CLK_SEL_EXT(CLK_SEL_EXT), .XTAL_OUT_O(XTAL_OUT_O),
   .XTAL_OUT_OE_N(XTAL_OUT_OE_N), .XTAL_IN_PULLDOWN(XTAL_IN_PULLDOWN),
   .AUX_PORT_BIT1(AUX_PORT_BIT1), .CAUSE_WATCHDOG(CAUSE_WATCHDOG));

/* File: bench/carc_xtal_model.sv */
// resonator and crystal-input pin model
// assumes osc_en from the block; drv_en/drv_val let the bench drive the pin
module carc_xtal_model
#(
   parameter int START = 3
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic osc_en,
   input  wire logic pull_en,
   input  wire logic drv_en,
   input  wire logic drv_val,
   output logic      osc_ok,
   output logic      xtal_in
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cnt_reg;
   logic tog_reg;
   // oscillator only counts up while powered; its count clears to zero when disabled
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg <= 0;
         tog_reg <= 1'b0;
      end
      else
      begin
         tog_reg <= ~tog_reg;
         cnt_reg <= !osc_en ? 0 : (cnt_reg < START ? cnt_reg + 1 : cnt_reg);
      end
   end
   assign osc_ok = osc_en && cnt_reg == START;
   // undriven pin: pull-down wins, otherwise the resonator swing shows
   assign xtal_in = drv_en ? drv_val : (pull_en ? 1'b0 : tog_reg);
endmodule

/* File: bench/carc_top_test.sv */
// self-checking bench for carc_top
// assumes the resonator model and shortened counts set below
module carc_top_test
   import carc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RS = 12, RL = 30, HOLD = 15, WB = 4, WATCH = 2000;
   typedef struct packed {logic [7:0] wa, wd, ra, rd; logic sel;} carc_row_t;
   carc_row_t rows [6] = '{'{8'hF8, 8'hAA, 8'hF8, 8'hAA, 1'b0}, '{8'hF8, 8'h54, 8'hF8, 8'h54, 1'b1},
      '{8'hF8, 8'hFE, 8'hF8, 8'hFE, 1'b0}, '{8'h26, 8'h5A, 8'h26, 8'h00, 1'b0},
      '{8'h10, 8'h33, 8'hF8, 8'hFE, 1'b0}, '{8'hF8, 8'h00, 8'h10, 8'h00, 1'b1}};
   logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, lv = 0, bo = 0, usb = 0, susp = 0, wake = 0;
   logic wie = 0, drv_en = 0, drv_val = 0, ce = 1, osc_ok, xin;
   logic [7:0] addr = 0, wdata = 0, rdata, d;
   logic [1:0] cclr = 0;
   logic sres, part, run, rz, core_en, ien, xen, sel_ext, tune, osel, oo, oe_n, pd, aux, wirq;
   logic c_lv, c_wd;
   logic [3:0] watch_v;
   int fails = 0, check_count = 0, n;
   assign watch_v = {core_en, wirq, sres, run};
   always #5 clk = ~clk;

   carc_top #(.P_STARTUP_CYC(20), .P_WATCH_CYC(WATCH), .P_STABLE_CYC(5), .P_RESUME_SHORT_CYC(RS),
      .P_RESUME_LONG_CYC(RL), .P_WDOG_HOLD_CYC(HOLD), .P_WAKE_BASE_CYC(WB)) u_dut (
      .SYS_CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .LV_BELOW(lv), .BROWNOUT_TRIP(bo), .EXT_OSC_OK(osc_ok), .XTAL_IN(xin),
      .USB_TRAFFIC(usb), .SUSPEND_REQ(susp), .WAKE_EVENT(wake), .WAKE_INT_EN(wie),
      .CAUSE_CLR(cclr), .SYS_RESET(sres), .PARTIAL_SUSPEND(part), .CPU_RUN(run),
      .RESTART_AT_ZERO(rz), .CORE_CLK_EN(core_en), .INT_OSC_EN(ien), .EXT_OSC_EN(xen),
      .CLK_SEL_EXT(sel_ext), .CLK_TUNE_EN(tune), .XTAL_OUT_CLK_SEL(osel), .XTAL_OUT_O(oo),
      .XTAL_OUT_OE_N(oe_n), .XTAL_IN_PULLDOWN(pd), .AUX_PORT_BIT1(aux), .WAKE_IRQ(wirq),
      .CAUSE_LV_BROWNOUT(c_lv), .CAUSE_WATCHDOG(c_wd));
   carc_xtal_model u_xtal (.clk(clk), .rst(rst), .osc_en(xen), .pull_en(pd),
      .drv_en(drv_en), .drv_val(drv_val), .osc_ok(osc_ok), .xtal_in(xin));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask
   // bounded wait on one watched output; running out ends the run
   task automatic wait_sig(input int s, input int lim, output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         #1 k++;
      end
      while (watch_v[s] !== 1'b1 && k < lim);
      if (watch_v[s] !== 1'b1)
      begin
         $display("[ERR] wait %0d expected 1 seen %b", s, watch_v[s]);
         fails++;
         tally_and_finish();
      end
   endtask
   task automatic pulse(input int s);
      @(posedge clk);
      {wake, susp, usb} <= 3'(1 << s);
      @(posedge clk);
      {wake, susp, usb} <= 3'b000;
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      $display("[ERR] run expected end seen hang");
      fails++;
      tally_and_finish();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      #1 chk("reset hold", 1, sres);
      chk("clock out", 1, osel & ien & ~sel_ext);
      @(posedge clk);
      rst <= 1'b0;
      wait_sig(0, 40, n);
      chk("restart", 1, rz);
      rd(ADDR_CLK_CFG, d);
      chk("cfg reset", 0, d);
      foreach (rows[i])
      begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra, d);
         chk("read", rows[i].rd, d);
         chk("clock out", rows[i].sel, osel);
      end
      drv_en <= 1'b1;
      drv_val <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk("aux high", 1, aux);
      drv_en <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("aux pulled", 0, aux);
      wr(ADDR_CLK_CFG, 8'h04);
      #1 chk("untuned", 0, tune);
      pulse(0);
      repeat (2) @(posedge clk);
      #1 chk("tuned", 1, tune);
      for (int a = 0; a < 8; a++)
      begin
         wr(ADDR_WDOG_CLR, 8'h00);
         wr(ADDR_CLK_CFG, 8'(a << 4));
         wie <= 1'b1;
         wait_sig(2, 600, n);
         wait_sig(2, 600, n);
         chk("wake period", WB << a, n);
         wie <= 1'b0;
      end
      wr(ADDR_CLK_CFG, 8'h08);
      lv <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("monitor off", 0, sres);
      wr(ADDR_CLK_CFG, 8'h00);
      repeat (6) @(posedge clk);
      #1 chk("low supply", 3, {sres, c_lv});
      lv <= 1'b0;
      wait_sig(0, 40, n);
      cclr <= 2'b01;
      @(posedge clk);
      cclr <= 2'b00;
      #1 chk("lv cause clr", 0, c_lv);
      wr(ADDR_CLK_CFG, 8'h08);
      bo <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("brown-out", 3, {sres, c_lv});
      bo <= 1'b0;
      wait_sig(0, 40, n);
      rd(ADDR_CLK_CFG, d);
      chk("monitor back", 0, d);
      wr(ADDR_CLK_CFG, 8'h01);
      #1 chk("halted", 0, core_en | ien);
      wait_sig(3, 40, n);
      wait_sig(0, 40, n);
      chk("short resume", RS, n);
      wr(ADDR_CLK_CFG, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk("still ext", 1, sel_ext);
      repeat (1500) @(posedge clk);
      wr(ADDR_WDOG_CLR, 8'hA5);
      wait_sig(1, WATCH + 10, n);
      chk("kick held off", WATCH, n);
      chk("dog cause", 3, {c_wd, sel_ext});
      wait_sig(0, 40, n);
      chk("dog hold", HOLD, n);
      cclr <= 2'b10;
      @(posedge clk);
      cclr <= 2'b00;
      #1 chk("dog cause clr", 0, c_wd);
      pulse(1);
      lv <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("suspend", 0, core_en | sres);
      lv <= 1'b0;
      pulse(2);
      // frozen cycles must not count towards the wake delay
      ce <= 1'b0;
      repeat (100) @(posedge clk);
      ce <= 1'b1;
      wait_sig(0, 900, n);
      chk("internal wake", 800, n);
      chk("back internal", 0, sel_ext);
      wr(ADDR_CLK_CFG, 8'h81);
      wait_sig(3, 40, n);
      wait_sig(0, 60, n);
      chk("long resume", RL, n);
      tally_and_finish();
   end
endmodule
